//--- design/udmf_consts.svh
`ifndef UDMF_CONSTS_SVH
`define UDMF_CONSTS_SVH

// buffer geometry
`define UDMF_WIDTH        8
`define UDMF_DEPTH        128
`define UDMF_CNT_W        8

// availability thresholds
`define UDMF_Q_FRAME      8'h0C
`define UDMF_TX_HIGH      8'h70
`define UDMF_TX_LOW       8'h10

// message framing
`define UDMF_GAP_ZEROS    4'h8
`define UDMF_ZERO_SAT     4'h9
`define UDMF_TX_FILL      3'h4
`define UDMF_LAST_BIT     3'h7

`endif

//--- design/udmf_pkg.sv
package udmf_pkg;

    typedef enum logic {RX_HUNT, RX_UNIT} udmf_rx_st_t;

    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_GAP} udmf_tx_st_t;

    // control levels and pulses from the control register
    typedef struct packed {
        logic tx_mode;
        logic q_decode;
        logic clear;
        logic ovr_clr;
    } udmf_ctrl_t;

    // serial user interface strobes and write data bit, one bit per pulse
    typedef struct packed {
        logic rd_shift;
        logic wr_shift;
        logic wr_bit;
    } udmf_host_t;

endpackage

//--- design/udmf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "udmf_consts.svh"

// --------------------------------------------------------------
// byte fifo
// --------------------------------------------------------------
module udmf_fifo #(
    parameter int W = 8,
    parameter int D = 128,
    parameter int CW = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          clear,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [CW-1:0]      count
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          push, pop;

    assign in_ready  = (cnt_r != CW'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign count     = cnt_r;
    assign push      = in_valid && in_ready && !clear;
    assign pop       = out_valid && out_ready && !clear;

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        if (clear) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

module udmf_top (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire udmf_pkg::udmf_ctrl_t ctrl,
    input  wire udmf_pkg::udmf_host_t host,
    input  wire logic                 rx_bit_valid,
    input  wire logic                 rx_user_bit,
    input  wire logic                 tx_bit_req,
    output logic                      tx_user_bit,
    output logic                      host_serial_line,
    output logic                      user_bytes_pending_n,
    output logic                      overrun
);
    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    udmf_pkg::udmf_rx_st_t rx_st_r, rx_st_nxt;
    udmf_pkg::udmf_tx_st_t tx_st_r, tx_st_nxt;
    logic [3:0] zero_r, zero_nxt;
    logic [2:0] rx_cnt_r, rx_cnt_nxt, q_cnt_r, q_cnt_nxt;
    logic [6:0] rx_sh_r, rx_sh_nxt, q_sh_r, q_sh_nxt;
    logic       first_r, first_nxt;
    logic       rx_push_r, rx_push_nxt;
    logic [7:0] rx_byte_r, rx_byte_nxt, unit;
    logic [2:0] wr_cnt_r, wr_cnt_nxt, rd_cnt_r, rd_cnt_nxt;
    logic [7:0] wr_sh_r, wr_sh_nxt, rd_sh_r, rd_sh_nxt;
    logic       wr_push_r, wr_push_nxt, rd_took_r, rd_took_nxt;
    logic       ser_r, ser_nxt, rd_pop;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [2:0] tx_cnt_r, tx_cnt_nxt;
    logic       tx_bit_r, tx_bit_nxt, tx_pop;
    logic       avail_n_r, avail_n_nxt, ovr_r, ovr_nxt;
    logic       f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_in_data, f_out_data;
    logic [7:0] f_count;

    // --------------------------------------------------------------
    // shared buffer
    // --------------------------------------------------------------
    assign f_in_valid  = ctrl.tx_mode ? wr_push_r : rx_push_r;
    assign f_in_data   = ctrl.tx_mode ? wr_sh_r : rx_byte_r;
    assign f_out_ready = ctrl.tx_mode ? tx_pop : rd_pop;

    udmf_fifo #(.W(`UDMF_WIDTH), .D(`UDMF_DEPTH), .CW(`UDMF_CNT_W)) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clear     (ctrl.clear),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data),
        .count     (f_count)
    );

    // --------------------------------------------------------------
    // receive message parser
    // --------------------------------------------------------------
    assign unit = {rx_sh_r, rx_user_bit};

    always_comb begin
        rx_st_nxt   = rx_st_r;
        zero_nxt    = zero_r;
        rx_cnt_nxt  = rx_cnt_r;
        rx_sh_nxt   = rx_sh_r;
        first_nxt   = first_r;
        q_cnt_nxt   = q_cnt_r;
        q_sh_nxt    = q_sh_r;
        rx_push_nxt = 1'b0;
        rx_byte_nxt = rx_byte_r;
        if (rx_bit_valid && !ctrl.tx_mode) begin
            unique case (rx_st_r)
                udmf_pkg::RX_HUNT: begin
                    if (rx_user_bit) begin
                        rx_st_nxt  = udmf_pkg::RX_UNIT;
                        rx_sh_nxt  = 7'h01;
                        rx_cnt_nxt = 3'h1;
                        first_nxt  = (zero_r > `UDMF_GAP_ZEROS);
                        zero_nxt   = 4'h0;
                    end else if (zero_r != `UDMF_ZERO_SAT) begin
                        zero_nxt = zero_r + 4'h1;
                    end
                end
                udmf_pkg::RX_UNIT: begin
                    rx_sh_nxt  = unit[6:0];
                    rx_cnt_nxt = rx_cnt_r + 3'h1;
                    if (rx_cnt_r == `UDMF_LAST_BIT) begin
                        rx_st_nxt = udmf_pkg::RX_HUNT;
                        if (ctrl.q_decode) begin
                            q_sh_nxt  = {q_sh_r[5:0], unit[6]};
                            q_cnt_nxt = q_cnt_r + 3'h1;
                            if (q_cnt_r == `UDMF_LAST_BIT) begin
                                rx_push_nxt = 1'b1;
                                rx_byte_nxt = {q_sh_r, unit[6]};
                            end
                        end else begin
                            rx_push_nxt = 1'b1;
                            rx_byte_nxt = {first_r, unit[6:0]};
                        end
                    end
                end
            endcase
        end
        if (ctrl.clear) begin
            q_cnt_nxt   = 3'h0;
            rx_push_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_st_r   <= udmf_pkg::RX_HUNT;
            zero_r    <= `UDMF_ZERO_SAT;
            rx_cnt_r  <= 3'h0;
            rx_sh_r   <= 7'h00;
            first_r   <= 1'b1;
            q_cnt_r   <= 3'h0;
            q_sh_r    <= 7'h00;
            rx_push_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            rx_st_r   <= rx_st_nxt;
            zero_r    <= zero_nxt;
            rx_cnt_r  <= rx_cnt_nxt;
            rx_sh_r   <= rx_sh_nxt;
            first_r   <= first_nxt;
            q_cnt_r   <= q_cnt_nxt;
            q_sh_r    <= q_sh_nxt;
            rx_push_r <= rx_push_nxt;
            rx_byte_r <= rx_byte_nxt;
        end
    end

    // --------------------------------------------------------------
    // host serial read and write
    // --------------------------------------------------------------
    assign rd_pop = host.rd_shift && (rd_cnt_r == `UDMF_LAST_BIT) && rd_took_r;

    always_comb begin
        rd_cnt_nxt  = rd_cnt_r;
        rd_sh_nxt   = rd_sh_r;
        rd_took_nxt = rd_took_r;
        ser_nxt     = ser_r;
        wr_cnt_nxt  = wr_cnt_r;
        wr_sh_nxt   = wr_sh_r;
        wr_push_nxt = 1'b0;
        if (host.rd_shift && !ctrl.tx_mode) begin
            rd_cnt_nxt = rd_cnt_r + 3'h1;
            if (rd_cnt_r == 3'h0) begin
                rd_took_nxt = f_out_valid;
                rd_sh_nxt   = f_out_valid ? f_out_data : 8'h00;
                ser_nxt     = f_out_valid && f_out_data[0];
            end else begin
                ser_nxt = rd_sh_r[rd_cnt_r];
            end
        end
        if (host.wr_shift && ctrl.tx_mode) begin
            wr_sh_nxt   = {host.wr_bit, wr_sh_r[7:1]};
            wr_cnt_nxt  = wr_cnt_r + 3'h1;
            wr_push_nxt = (wr_cnt_r == `UDMF_LAST_BIT);
        end
        if (ctrl.clear) begin
            rd_cnt_nxt  = 3'h0;
            wr_cnt_nxt  = 3'h0;
            wr_push_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_cnt_r  <= 3'h0;
            rd_sh_r   <= 8'h00;
            rd_took_r <= 1'b0;
            ser_r     <= 1'b0;
            wr_cnt_r  <= 3'h0;
            wr_sh_r   <= 8'h00;
            wr_push_r <= 1'b0;
        end else begin
            rd_cnt_r  <= rd_cnt_nxt;
            rd_sh_r   <= rd_sh_nxt;
            rd_took_r <= rd_took_nxt;
            ser_r     <= ser_nxt;
            wr_cnt_r  <= wr_cnt_nxt;
            wr_sh_r   <= wr_sh_nxt;
            wr_push_r <= wr_push_nxt;
        end
    end

    // --------------------------------------------------------------
    // transmit serializer
    // --------------------------------------------------------------
    assign tx_pop = ctrl.tx_mode && tx_bit_req && (tx_st_r == udmf_pkg::TX_IDLE) && f_out_valid;

    always_comb begin
        tx_st_nxt  = tx_st_r;
        tx_sh_nxt  = tx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_bit_nxt = tx_bit_r;
        if (tx_bit_req && ctrl.tx_mode) begin
            tx_cnt_nxt = tx_cnt_r + 3'h1;
            unique case (tx_st_r)
                udmf_pkg::TX_IDLE: begin
                    tx_bit_nxt = f_out_valid && f_out_data[7];
                    tx_sh_nxt  = {f_out_data[6:0], 1'b0};
                    tx_cnt_nxt = 3'h1;
                    if (f_out_valid) begin
                        tx_st_nxt = udmf_pkg::TX_DATA;
                    end
                end
                udmf_pkg::TX_DATA: begin
                    tx_bit_nxt = tx_sh_r[7];
                    tx_sh_nxt  = {tx_sh_r[6:0], 1'b0};
                    if (tx_cnt_r == `UDMF_LAST_BIT) begin
                        tx_st_nxt  = udmf_pkg::TX_GAP;
                        tx_cnt_nxt = 3'h0;
                    end
                end
                udmf_pkg::TX_GAP: begin
                    tx_bit_nxt = 1'b0;
                    if (tx_cnt_r == `UDMF_TX_FILL - 3'h1) begin
                        tx_st_nxt = udmf_pkg::TX_IDLE;
                    end
                end
                default: tx_st_nxt = udmf_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_st_r  <= udmf_pkg::TX_IDLE;
            tx_sh_r  <= 8'h00;
            tx_cnt_r <= 3'h0;
            tx_bit_r <= 1'b0;
        end else begin
            tx_st_r  <= tx_st_nxt;
            tx_sh_r  <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
        end
    end

    // --------------------------------------------------------------
    // availability and overrun
    // --------------------------------------------------------------
    always_comb begin
        avail_n_nxt = avail_n_r;
        if (ctrl.tx_mode) begin
            if (f_count >= `UDMF_TX_HIGH) begin
                avail_n_nxt = 1'b1;
            end else if (f_count <= `UDMF_TX_LOW) begin
                avail_n_nxt = 1'b0;
            end
        end else if (ctrl.q_decode) begin
            avail_n_nxt = (f_count < `UDMF_Q_FRAME);
        end else begin
            avail_n_nxt = (f_count == 8'h00);
        end
        if (ctrl.clear) begin
            avail_n_nxt = 1'b1;
        end
        ovr_nxt = ovr_r;
        if (ctrl.ovr_clr) begin
            ovr_nxt = 1'b0;
        end
        if (f_in_valid && !f_in_ready && !ctrl.clear) begin
            ovr_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            avail_n_r <= 1'b1;
            ovr_r     <= 1'b0;
        end else begin
            avail_n_r <= avail_n_nxt;
            ovr_r     <= ovr_nxt;
        end
    end

    assign tx_user_bit          = tx_bit_r;
    assign host_serial_line     = ser_r;
    assign user_bytes_pending_n = avail_n_r;
    assign overrun              = ovr_r;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_unit_done;
        rx_bit_valid && !ctrl.tx_mode && !ctrl.clear && rx_st_r == udmf_pkg::RX_UNIT && rx_cnt_r == 3'h7;
    endsequence

    a_rx_unit_push: assert property (@(posedge sys_clk) disable iff (reset)
        s_unit_done ##0 !ctrl.q_decode |=> rx_push_r && rx_byte_r[6:0] == $past(unit[6:0]))
        else $error("completed unit not pushed");
    a_msg_start_flag: assert property (@(posedge sys_clk) disable iff (reset)
        s_unit_done ##0 !ctrl.q_decode |=> rx_byte_r[7] == $past(first_r))
        else $error("message start flag wrong");
    a_q_pack_byte: assert property (@(posedge sys_clk) disable iff (reset)
        s_unit_done ##0 ctrl.q_decode && q_cnt_r == 3'h7 |=> rx_push_r && rx_byte_r[0] == $past(unit[6]))
        else $error("q byte not packed");
    a_clear_avail_hi: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl.clear |=> user_bytes_pending_n && f_count == 8'h00)
        else $error("clear did not raise availability");
    a_q_avail_lvl: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrl.tx_mode && ctrl.q_decode && !ctrl.clear |=> user_bytes_pending_n == ($past(f_count) < 8'h0C))
        else $error("q availability wrong");
    a_norm_avail_lvl: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrl.tx_mode && !ctrl.q_decode && !ctrl.clear |=> user_bytes_pending_n == ($past(f_count) == 8'h00))
        else $error("normal availability wrong");
    a_tx_hyst_high: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl.tx_mode && f_count >= 8'h70 |=> user_bytes_pending_n)
        else $error("tx availability not high");
    a_tx_hyst_low: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl.tx_mode && !ctrl.clear && f_count <= 8'h10 |=> !user_bytes_pending_n)
        else $error("tx availability not low");
    a_full_overrun: assert property (@(posedge sys_clk) disable iff (reset)
        f_in_valid && f_count == 8'h80 && !ctrl.clear |=> overrun && f_count <= 8'h80)
        else $error("overrun not flagged");
    a_tx_empty_zero: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl.tx_mode && tx_bit_req && tx_st_r == udmf_pkg::TX_IDLE && !f_out_valid |=> !tx_user_bit)
        else $error("empty buffer sent a one");
    a_tx_gap_zero: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl.tx_mode && tx_bit_req && tx_st_r == udmf_pkg::TX_GAP |=> !tx_user_bit)
        else $error("gap bit not zero");
    a_wr_commit: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl.tx_mode && host.wr_shift && wr_cnt_r == 3'h7 && !ctrl.clear |=> wr_push_r ##1 !wr_push_r)
        else $error("host byte not committed once");
endmodule

`default_nettype wire

//--- tb/udmf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host microcontroller model
// ----------------------------------------
module udmf_host_model (
    input  wire logic          sys_clk,
    input  wire logic          host_serial_line,
    input  wire logic          user_bytes_pending_n,
    output udmf_pkg::udmf_host_t host
);
    initial begin
        host = '0;
    end

    // read one byte lsb first, optionally polling availability first
    task automatic read_byte(input logic poll, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b1;
        while (poll && user_bytes_pending_n !== 1'b0) begin
            @(posedge sys_clk);
            n++;
            if (n > 2000) begin
                ok = 1'b0;
                return;
            end
        end
        @(posedge sys_clk);
        host.rd_shift <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            if (i == 7) begin
                host.rd_shift <= 1'b0;
            end
            #1 b[i] = host_serial_line;
        end
    endtask

    // write one byte lsb first, general format only
    task automatic write_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            host.wr_shift <= 1'b1;
            host.wr_bit   <= b[i];
        end
        @(posedge sys_clk);
        host.wr_shift <= 1'b0;
        host.wr_bit   <= ~b[7];
    endtask
endmodule
`default_nettype wire

//--- tb/user_data_message_fifo_tb.sv
`timescale 1ns/1ps
`default_nettype none
module user_data_message_fifo_tb;
    logic                 sys_clk;
    logic                 reset;
    logic                 rx_bit_valid;
    logic                 rx_user_bit;
    logic                 tx_bit_req;
    udmf_pkg::udmf_ctrl_t ctrl;
    wire udmf_pkg::udmf_host_t host;
    wire logic            tx_user_bit;
    wire logic            host_serial_line;
    wire logic            user_bytes_pending_n;
    wire logic            overrun;
    int                   err_count;
    int                   compares;
    int                   qn;
    logic [7:0]           qacc;
    logic [7:0]           b;
    logic [11:0]          v;
    logic [7:0]           exp_q[$];

    udmf_top u_dut (.sys_clk(sys_clk), .reset(reset), .ctrl(ctrl), .host(host), .rx_bit_valid(rx_bit_valid),
        .rx_user_bit(rx_user_bit), .tx_bit_req(tx_bit_req), .tx_user_bit(tx_user_bit),
        .host_serial_line(host_serial_line), .user_bytes_pending_n(user_bytes_pending_n), .overrun(overrun));
    udmf_host_model u_host (.sys_clk(sys_clk), .host_serial_line(host_serial_line),
        .user_bytes_pending_n(user_bytes_pending_n), .host(host));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_pend(input logic lvl);
        int n;
        n = 0;
        compares++;
        while (user_bytes_pending_n !== lvl) begin
            @(posedge sys_clk);
            n++;
            if (n > 20) begin
                err_count++;
                $display("BAD %0t availability stuck", $time);
                stop_test();
            end
        end
    endtask

    task automatic rd(input logic poll, output logic [7:0] d);
        logic ok;
        u_host.read_byte(poll, d, ok);
        if (!ok) begin
            err_count++;
            $display("BAD %0t read wait expired", $time);
            stop_test();
        end
    endtask

    task automatic pulse(input logic clr);
        @(posedge sys_clk);
        ctrl.clear   <= clr;
        ctrl.ovr_clr <= ~clr;
        @(posedge sys_clk);
        ctrl.clear   <= 1'b0;
        ctrl.ovr_clr <= 1'b0;
    endtask

    task automatic rx_bit(input logic x);
        @(posedge sys_clk);
        rx_bit_valid <= 1'b1;
        rx_user_bit  <= x;
    endtask

    task automatic rx_idle();
        @(posedge sys_clk);
        rx_bit_valid <= 1'b0;
        rx_user_bit  <= ~rx_user_bit;
        repeat (6) @(posedge sys_clk);
    endtask

    // units with zero gaps; reference model keeps the expected buffer
    task automatic rx_msg(input int n, input int start_gap);
        int gap;
        logic [7:0] u;
        for (int k = 0; k < n; k++) begin
            gap = (k == 0) ? start_gap : (k == 1) ? 8 : $urandom_range(0, 8);
            u = {1'b1, 7'($urandom)};
            repeat (gap) rx_bit(1'b0);
            for (int i = 7; i >= 0; i--) rx_bit(u[i]);
            if (ctrl.q_decode) begin
                qacc = {qacc[6:0], u[6]};
                qn++;
                if (qn == 8) begin
                    exp_q.push_back(qacc);
                    qn = 0;
                end
            end else if (exp_q.size() < 128) begin
                exp_q.push_back({gap > 8, u[6:0]});
            end
        end
    endtask

    task automatic drain();
        while (exp_q.size() > 0) begin
            rd(1'b1, b);
            chk(b, exp_q.pop_front());
            if (exp_q.size() > 0) begin
                @(posedge sys_clk);
                #1 chk({7'h00, user_bytes_pending_n}, 8'h00);
            end
        end
        wait_pend(1'b1);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        ctrl = '0;
        rx_bit_valid = 1'b0;
        rx_user_bit = 1'b0;
        tx_bit_req = 1'b0;
        err_count = 0;
        compares = 0;
        qn = 0;
        qacc = 8'h00;
        void'($urandom(32'h7F642219));
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk({4'h0, tx_user_bit, host_serial_line, overrun, user_bytes_pending_n}, 8'h01);

        rx_msg(5, 9);
        rx_msg(4, 12);
        rx_idle();
        drain();
        rd(1'b0, b);
        chk(b, 8'h00);

        rx_msg(130, 9);
        rx_idle();
        chk({7'h00, overrun}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            rd(1'b1, b);
            chk(b, exp_q.pop_front());
        end
        rx_msg(1, 9);
        rx_idle();
        drain();
        rx_msg(3, 9);
        rx_idle();
        wait_pend(1'b0);
        pulse(1'b1);
        exp_q.delete();
        wait_pend(1'b1);
        pulse(1'b0);
        #1 chk({7'h00, overrun}, 8'h00);

        @(posedge sys_clk);
        ctrl.q_decode <= 1'b1;
        rx_msg(88, 9);
        rx_idle();
        chk({7'h00, user_bytes_pending_n}, 8'h01);
        rx_msg(8, 12);
        rx_idle();
        wait_pend(1'b0);
        for (int i = 0; i < 12; i++) begin
            rd(i == 0, b);
            chk(b, exp_q.pop_front());
        end
        wait_pend(1'b1);
        @(posedge sys_clk);
        ctrl.q_decode <= 1'b0;
        ctrl.tx_mode  <= 1'b1;

        for (int k = 0; k < 129; k++) begin
            b = (k == 0) ? 8'h00 : 8'($urandom);
            u_host.write_byte(b);
            if (k < 128) exp_q.push_back(b);
            if (k == 110) begin
                repeat (3) @(posedge sys_clk);
                #1 chk({7'h00, user_bytes_pending_n}, 8'h00);
            end
            if (k == 111) wait_pend(1'b1);
        end
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h00, overrun}, 8'h01);
        for (int k = 0; k < 129; k++) begin
            for (int i = 0; i < 12; i++) begin
                @(posedge sys_clk);
                tx_bit_req <= 1'b1;
                @(posedge sys_clk);
                tx_bit_req <= 1'b0;
                #1 v = {v[10:0], tx_user_bit};
            end
            chk(v[11:4], (k < 128) ? exp_q.pop_front() : 8'h00);
            chk({4'h0, v[3:0]}, 8'h00);
            if (k < 128) chk({7'h00, user_bytes_pending_n}, {7'h00, (127 - k) > 16});
        end
        stop_test();
    end
endmodule
`default_nettype wire
